//--- src/mkng_top.sv
`timescale 1ns/1ps
// Behaviour
// - scan twelve select lines by six returns: 61 keys plus six commands
// - select outputs active low, only the selected line low
// - returns active low, high when no switch closed
// - right priority plays the rightmost pressed key
// - left priority plays the nth pressed key from left, n up to twelve
// - priority key select only matters in left-priority mode
// - glide across one semitone takes sixteen oscillator periods
// - glide time grows linearly with semitone distance
// - sync reset realigns scanning; held low with a single device
// - clamp reset clears footage squares, foot/duty output, zeroing pulse
// - octave as 3-bit code, largest code for lowest octave
// - foot/duty output: 8' 12.5% or 25%, 16' 6.25% or 12.5%
// - sawtooth zeroing pulse lasts 16 to 24 us at 2 MHz
// - key level high with no key, low while any key pressed
// - trigger rests high, goes low 8 ms on an event
// - trigger on first key, new priority key, or priority handover
// - four 50% squares an octave apart, top 8372 Hz
// - footage squares change only on a rising clock edge
// - a new key reaches the outputs within 0.5 ms
// - after all keys released the last note keeps sounding
// - each semitone split into eight steps of about 2^(1/96)
// - octave codes low to high 111,011,101,001,110,010 as a/b/c
// - foot/duty commands read on return six at selects five and six
module mkng_top #(
    parameter int TRIG_CYCLES = mkng_pkg::MKNG_TRIG_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sync_reset,
    input wire logic pitch_clamp_reset,
    input wire logic [mkng_pkg::MKNG_RET_LINES-1:0] octave_return_n,
    input wire logic priority_key_select,
    input wire logic priority_right,
    input wire logic ext_glide_osc_in,
    input wire logic rc_glide_osc_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [mkng_pkg::MKNG_SEL_LINES-1:0] note_select_n,
    output logic any_key_level,
    output logic priority_trigger_pulse,
    output logic octave_code_bit0,
    output logic octave_code_bit1,
    output logic octave_code_bit2,
    output logic [3:0] footage_square,
    output logic footduty_out,
    output logic zero_pulse_out
);
    import mkng_pkg::*;

    logic [3:0] sel_idx;
    logic [11:0] slot_cnt;
    logic slot_end;
    logic [MKNG_KEYS-1:0] scan_keys;
    logic [MKNG_KEYS-1:0] next_scan;
    logic [MKNG_KEYS-1:0] pressed;
    logic bc_seen;
    logic [3:0] bc_slot;
    logic next_bc_seen;
    logic [3:0] next_bc_slot;
    logic [3:0] left_rank;
    mkng_cmd_t cmd;
    logic pick_valid;
    logic [5:0] pick_idx;
    logic [5:0] key_idx;
    mkng_note_t key_note;
    logic have_key;
    logic trig_start;
    logic trig_active;
    logic glide_on;
    logic osc_now;
    logic osc_q;
    logic edge_par;
    logic glide_tick;
    mkng_pitch_t cur;
    mkng_pitch_t target;
    logic [19:0] base_lo;
    logic [19:0] base_hi;
    logic [22:0] span;
    logic [19:0] interp;
    logic [MKNG_INC_W-1:0] inc_q;
    logic [MKNG_ACC_W-1:0] acc;
    logic saw_bit;
    logic saw_q;
    logic zero_start;
    logic zero_active;
    logic wait_q;
    logic [31:0] low_cnt;

    // avalon slave: one wait cycle, then the access completes
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end
    assign avs_waitrequest = wait_q;

    // control register; glide is steered from here, not from a pin
    always_ff @(posedge clock) begin
        if (!resetn) begin
            glide_on <= MKNG_CTRL_GLIDE_RESET;
        end else if (avs_write && !wait_q && avs_byteenable[0]) begin
            if (avs_address == MKNG_CTRL_ADDR) begin
                glide_on <= avs_writedata[MKNG_CTRL_GLIDE_BIT];
            end
        end
    end

    // read data is captured in the wait cycle so it stands when waitrequest drops
    always_ff @(posedge clock) begin
        if (!resetn) begin
            avs_readdata <= '0;
        end else if (avs_read && wait_q) begin
            if (avs_address == MKNG_CTRL_ADDR) begin
                avs_readdata <= {31'h00000000, glide_on};
            end else if (avs_address == MKNG_STATUS_ADDR) begin
                avs_readdata <= {14'h0000, cur, have_key, trig_active, key_idx};
            end else begin
                avs_readdata <= '0;
            end
        end
    end

    // slot timer and select index; sync reset realigns with a partner device
    assign slot_end = (slot_cnt == 12'(MKNG_SLOT_CYCLES - 1));
    always_ff @(posedge clock) begin
        if (!resetn || sync_reset) begin
            sel_idx <= '0;
            slot_cnt <= '0;
        end else if (slot_end) begin
            slot_cnt <= '0;
            if (sel_idx == 4'(MKNG_SEL_LINES - 1)) begin
                sel_idx <= '0;
            end else begin
                sel_idx <= sel_idx + 4'h1;
            end
        end else begin
            slot_cnt <= slot_cnt + 12'h001;
        end
    end

    // exactly one select line low at a time
    always_ff @(posedge clock) begin
        if (!resetn) begin
            note_select_n <= MKNG_SEL_RESET;
        end else begin
            note_select_n <= ~(12'h001 << sel_idx);
        end
    end

    // returns read low for a closed switch; return six holds the top key at select 0, six of the rest are commands
    always_comb begin
        next_scan = scan_keys;
        for (int r = 0; r < MKNG_RET_LINES - 1; r++) begin
            next_scan[r * MKNG_SEL_LINES + int'(sel_idx)] = ~octave_return_n[r];
        end
        if (sel_idx == 4'h0) begin
            next_scan[MKNG_TOP_KEY] = ~octave_return_n[MKNG_CMD_RET];
        end
    end

    // the key set is only published after a full pass, so a half scan never plays
    always_ff @(posedge clock) begin
        if (!resetn || sync_reset) begin
            scan_keys <= '0;
        end else if (slot_end) begin
            if (sel_idx == 4'(MKNG_SEL_LINES - 1)) begin
                scan_keys <= '0;
            end else begin
                scan_keys <= next_scan;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pressed <= '0;
        end else if (slot_end && sel_idx == 4'(MKNG_SEL_LINES - 1)) begin
            pressed <= next_scan;
        end
    end

    // command switches on return six
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cmd <= '0;
        end else if (slot_end) begin
            if (sel_idx == 4'(MKNG_CMD_A_SLOT)) begin
                cmd.cmd_a <= ~octave_return_n[MKNG_CMD_RET];
            end else if (sel_idx == 4'(MKNG_CMD_B_SLOT)) begin
                cmd.cmd_b <= ~octave_return_n[MKNG_CMD_RET];
            end else if (sel_idx >= 4'(MKNG_SAW_FIRST_SLOT)) begin
                cmd.saw[2'(sel_idx - 4'(MKNG_SAW_FIRST_SLOT))] <= ~octave_return_n[MKNG_CMD_RET];
            end
        end
    end

    // rank for left priority: first slot in a pass where the select input reads low
    always_comb begin
        next_bc_seen = (sel_idx == 4'h0) ? 1'b0 : bc_seen;
        next_bc_slot = (sel_idx == 4'h0) ? 4'h0 : bc_slot;
        if (!next_bc_seen && !priority_key_select) begin
            next_bc_seen = 1'b1;
            next_bc_slot = sel_idx;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            bc_seen <= 1'b0;
            bc_slot <= '0;
            left_rank <= '0;
        end else if (slot_end) begin
            bc_seen <= next_bc_seen;
            bc_slot <= next_bc_slot;
            if (sel_idx == 4'(MKNG_SEL_LINES - 1)) begin
                left_rank <= next_bc_seen ? next_bc_slot : 4'h0;
            end
        end
    end

    // pick the playing key; short of n keys, left mode plays the last counted
    always_comb begin
        int count;
        count = 0;
        pick_valid = 1'b0;
        pick_idx = '0;
        for (int i = 0; i < MKNG_KEYS; i++) begin
            if (pressed[i]) begin
                if (priority_right || count <= int'(left_rank)) begin
                    pick_idx = 6'(i);
                end
                count = count + 1;
                pick_valid = 1'b1;
            end
        end
    end

    // held key survives release of all keys; a changed pick raises a trigger
    always_ff @(posedge clock) begin
        if (!resetn) begin
            key_idx <= '0;
            key_note <= '0;
            have_key <= 1'b0;
            trig_start <= 1'b0;
        end else begin
            trig_start <= pick_valid && (!have_key || pick_idx != key_idx);
            have_key <= pick_valid;
            if (pick_valid) begin
                key_idx <= pick_idx;
                key_note.oct <= 3'(pick_idx / 6'(MKNG_SEL_LINES));
                key_note.semi <= 4'(pick_idx % 6'(MKNG_SEL_LINES));
            end
        end
    end

    mkng_pulse #(
        .COUNT(TRIG_CYCLES)
    ) u_trig (
        .clock(clock),
        .resetn(resetn),
        .clear(1'b0),
        .start(trig_start),
        .active(trig_active)
    );

    // key level and trigger are driven from flops, idle high
    always_ff @(posedge clock) begin
        if (!resetn) begin
            any_key_level <= 1'b1;
            priority_trigger_pulse <= 1'b1;
        end else begin
            any_key_level <= ~pick_valid;
            priority_trigger_pulse <= ~trig_active;
        end
    end

    // both oscillator pins are ored: the idle one must sit low
    assign osc_now = ext_glide_osc_in | rc_glide_osc_in;
    assign glide_tick = osc_now && !osc_q && edge_par;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            osc_q <= 1'b0;
            edge_par <= 1'b0;
        end else begin
            osc_q <= osc_now;
            if (osc_now && !osc_q) begin
                edge_par <= ~edge_par;
            end
        end
    end

    function automatic mkng_pitch_t step_up(input mkng_pitch_t p);
        mkng_pitch_t q;
        q = p;
        if (p.frac != 3'h7) begin
            q.frac = p.frac + 3'h1;
        end else begin
            q.frac = 3'h0;
            if (p.semi == 4'(MKNG_SEL_LINES - 1)) begin
                q.semi = 4'h0;
                q.oct = p.oct + 3'h1;
            end else begin
                q.semi = p.semi + 4'h1;
            end
        end
        return q;
    endfunction

    function automatic mkng_pitch_t step_down(input mkng_pitch_t p);
        mkng_pitch_t q;
        q = p;
        if (p.frac != 3'h0) begin
            q.frac = p.frac - 3'h1;
        end else begin
            q.frac = 3'h7;
            if (p.semi == 4'h0) begin
                q.semi = 4'(MKNG_SEL_LINES - 1);
                q.oct = p.oct - 3'h1;
            end else begin
                q.semi = p.semi - 4'h1;
            end
        end
        return q;
    endfunction

    // glide: one eighth-semitone per tick, so time is linear in distance
    assign target = {key_note, 3'h0};
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cur <= '0;
        end else if (!glide_on) begin
            cur <= target;
        end else if (glide_tick) begin
            if (cur < target) begin
                cur <= step_up(cur);
            end else if (cur > target) begin
                cur <= step_down(cur);
            end
        end
    end

    // linear interpolation between semitones stands in for the 96th-root ladder
    always_comb begin
        base_lo = MKNG_BASE_INC[cur.semi];
        base_hi = MKNG_BASE_INC[cur.semi + 4'h1];
        span = 23'(base_hi - base_lo) * 23'(cur.frac);
        interp = base_lo + 20'(span >> 3);
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            inc_q <= '0;
        end else begin
            inc_q <= interp >> (3'(MKNG_TOP_OCT) - cur.oct);
        end
    end

    // phase accumulator: bits 31..34 are the 2', 4', 8', 16' squares
    always_ff @(posedge clock) begin
        if (!resetn || pitch_clamp_reset) begin
            acc <= '0;
        end else begin
            acc <= acc + MKNG_ACC_W'(inc_q);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || pitch_clamp_reset) begin
            footage_square <= 4'h0;
            footduty_out <= 1'b0;
        end else begin
            footage_square <= acc[34:31];
            case ({cmd.cmd_b, cmd.cmd_a})
                2'h0: footduty_out <= &acc[33:31];
                2'h1: footduty_out <= &acc[33:32];
                2'h2: footduty_out <= &acc[34:31];
                default: footduty_out <= &acc[34:32];
            endcase
        end
    end

    // zeroing pulse on the rising edge of the chosen sawtooth footage
    always_comb begin
        if (cmd.saw[0]) begin
            saw_bit = acc[35];
        end else if (cmd.saw[1]) begin
            saw_bit = acc[34];
        end else if (cmd.saw[2]) begin
            saw_bit = acc[33];
        end else begin
            saw_bit = acc[32];
        end
    end
    assign zero_start = saw_bit && !saw_q;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            saw_q <= 1'b0;
        end else begin
            saw_q <= saw_bit;
        end
    end

    mkng_pulse #(
        .COUNT(MKNG_ZERO_CYCLES)
    ) u_zero (
        .clock(clock),
        .resetn(resetn),
        .clear(pitch_clamp_reset),
        .start(zero_start),
        .active(zero_active)
    );

    // octave code and zeroing output; code counts down as the octave rises
    always_ff @(posedge clock) begin
        if (!resetn) begin
            {octave_code_bit2, octave_code_bit1, octave_code_bit0} <= MKNG_OCT_CODE_LOW;
            zero_pulse_out <= 1'b0;
        end else begin
            {octave_code_bit2, octave_code_bit1, octave_code_bit0} <=
                MKNG_OCT_CODE_LOW - cur.oct;
            zero_pulse_out <= zero_active && !pitch_clamp_reset;
        end
    end

    // helper: length of the current low phase of the trigger
    always_ff @(posedge clock) begin
        if (!resetn || priority_trigger_pulse) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + 32'h00000001;
        end
    end

    default clocking mkng_cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence seq_key_change;
        pick_valid && (!have_key || pick_idx != key_idx);
    endsequence

    // trig_start, one-shot and output flop each add a cycle
    sequence seq_trig_low;
        ##3 !priority_trigger_pulse;
    endsequence

    a_select_onehot: assert property ($countones(~note_select_n) == 1)
        else $error("select lines not exactly one low");
    a_scan_order: assert property (slot_end && !sync_reset |=>
        sel_idx == (($past(sel_idx) == 4'hB) ? 4'h0 : $past(sel_idx) + 4'h1))
        else $error("select index did not advance in order");
    a_sync_align: assert property (sync_reset |=> sel_idx == 4'h0 && slot_cnt == 12'h000)
        else $error("sync reset did not restart the scan");
    a_right_pick: assert property (pick_valid && priority_right |->
        (pressed >> pick_idx) == 61'(1))
        else $error("right priority did not pick the rightmost key");
    a_left_rank: assert property (pick_valid && !priority_right |->
        $countones(pressed & ((61'(1) << pick_idx) - 61'(1))) <= int'(left_rank))
        else $error("left priority picked beyond its rank");
    a_trig_event: assert property (seq_key_change |-> seq_trig_low)
        else $error("key change did not pull the trigger low");
    a_trig_width: assert property ($rose(priority_trigger_pulse) |->
        low_cnt >= 32'(TRIG_CYCLES))
        else $error("trigger low phase too short");
    a_key_level: assert property ((|pressed) |=> !any_key_level)
        else $error("key level high while a key is pressed");
    a_glide_hold: assert property (glide_on && !glide_tick |=> $stable(cur))
        else $error("pitch moved without a glide tick");
    a_glide_step: assert property (glide_on && glide_tick && cur != target |=>
        cur != $past(cur))
        else $error("glide tick did not step the pitch");
    a_octave_code: assert property (##1 {octave_code_bit2, octave_code_bit1, octave_code_bit0}
        == 3'h7 - $past(cur.oct))
        else $error("octave code does not follow the octave");
    a_clamp_clear: assert property (pitch_clamp_reset |=>
        footage_square == 4'h0 && !footduty_out && !zero_pulse_out)
        else $error("clamp reset left an output active");
    a_zero_fire: assert property (zero_start && !pitch_clamp_reset ##1 !pitch_clamp_reset
        |=> zero_pulse_out)
        else $error("sawtooth edge did not fire the zeroing pulse");
endmodule

//--- src/mkng_pkg.sv
package mkng_pkg;
    // matrix geometry
    localparam int MKNG_SEL_LINES = 12;
    localparam int MKNG_RET_LINES = 6;
    localparam int MKNG_KEYS = 61;
    localparam int MKNG_TOP_KEY = 60;
    localparam int MKNG_CMD_RET = 5;
    localparam int MKNG_CMD_A_SLOT = 4;
    localparam int MKNG_CMD_B_SLOT = 5;
    localparam int MKNG_SAW_FIRST_SLOT = 8;
    localparam logic [11:0] MKNG_SEL_RESET = 12'hFFE;

    // timing, clock period 5 ns
    localparam int MKNG_CLK_PERIOD_NS = 5;
    localparam int MKNG_SLOT_NS = 10000;
    localparam int MKNG_SLOT_CYCLES = MKNG_SLOT_NS / MKNG_CLK_PERIOD_NS;
    localparam int MKNG_ZERO_PULSE_NS = 20000;
    localparam int MKNG_ZERO_CYCLES = MKNG_ZERO_PULSE_NS / MKNG_CLK_PERIOD_NS;
    localparam int MKNG_TRIG_PULSE_US = 8000;
    localparam int MKNG_TRIG_CYCLES = MKNG_TRIG_PULSE_US * 1000 / MKNG_CLK_PERIOD_NS;

    // pitch generation
    localparam int MKNG_TOP_OCT = 5;
    localparam int MKNG_ACC_W = 36;
    localparam int MKNG_INC_W = 20;
    localparam logic [2:0] MKNG_OCT_CODE_LOW = 3'h7;

    // register map, byte addresses
    localparam logic [3:0] MKNG_CTRL_ADDR = 4'h0;
    localparam logic [3:0] MKNG_STATUS_ADDR = 4'h4;
    localparam int MKNG_CTRL_GLIDE_BIT = 0;
    localparam logic MKNG_CTRL_GLIDE_RESET = 1'b1;

    typedef struct packed {
        logic [2:0] oct;
        logic [3:0] semi;
    } mkng_note_t;

    typedef struct packed {
        logic [2:0] oct;
        logic [3:0] semi;
        logic [2:0] frac;
    } mkng_pitch_t;

    typedef struct packed {
        logic cmd_a;
        logic cmd_b;
        logic [3:0] saw;
    } mkng_cmd_t;

    // top-octave phase increments, C6 up to C7, for a 2^32 phase at 200 MHz
    localparam logic [19:0] MKNG_BASE_INC [13] = '{
        20'h2BE4C, 20'h2E80E, 20'h3144D, 20'h3432D, 20'h374D6, 20'h3A974, 20'h3E132,
        20'h41C41, 20'h45AD3, 20'h49D1E, 20'h4E359, 20'h52DC2, 20'h57C97
    };
endpackage

//--- src/mkng_pulse.sv
`timescale 1ns/1ps
module mkng_pulse #(
    parameter int COUNT = mkng_pkg::MKNG_ZERO_CYCLES,
    parameter int CW = $clog2(COUNT + 1)
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clear,
    input wire logic start,
    output logic active
);
    import mkng_pkg::*;

    logic [CW-1:0] remain;

    // one-shot; a new start re-arms the full length
    always_ff @(posedge clock) begin
        if (!resetn || clear) begin
            remain <= '0;
            active <= 1'b0;
        end else if (start) begin
            remain <= CW'(COUNT - 1);
            active <= 1'b1;
        end else if (remain != '0) begin
            remain <= remain - CW'(1);
        end else begin
            active <= 1'b0;
        end
    end

    a_pulse_start: assert property (@(posedge clock) disable iff (!resetn)
        start && !clear |=> active && remain == CW'(COUNT - 1))
        else $error("one-shot did not arm on start");
endmodule

//--- tb/mkng_kbd_model.sv
`timescale 1ns/1ps
// keyboard matrix with pull-ups, so an open return reads high
module mkng_kbd_model (
    input wire logic [11:0] note_select_n,
    input wire logic [60:0] pressed,
    output logic [5:0] octave_return_n,
    output logic priority_key_select
);
    // left rank strapped to the first key
    assign priority_key_select = 1'b0;
    // a closed switch pulls its return low only while its line is selected
    always_comb begin
        octave_return_n = 6'h3F;
        for (int s = 0; s < 12; s++) begin
            for (int r = 0; r < 5; r++) begin
                if (!note_select_n[s] && pressed[r*12+s]) octave_return_n[r] = 1'b0;
            end
        end
        // command switches stay open, top key sits on return six at line 0
        if (!note_select_n[0] && pressed[60]) octave_return_n[5] = 1'b0;
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import mkng_pkg::*;
    logic clock = 0, resetn = 0, sync_reset = 0, priority_right = 1;
    logic clamp = 0, osc = 0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, any_key_level, trig, ob0, ob1, ob2, footduty_out, zero_pulse_out;
    logic [11:0] note_select_n;
    logic [5:0] ret_n;
    logic pks;
    logic [3:0] footage_square;
    logic [60:0] pressed = '0;
    int fails = 0, check_count = 0, cyc = 0, low_cnt = 0;
    mkng_top #(.TRIG_CYCLES(50)) mkng_top_i (.clock(clock), .resetn(resetn),
        .sync_reset(sync_reset), .pitch_clamp_reset(clamp), .octave_return_n(ret_n),
        .priority_key_select(pks), .priority_right(priority_right), .ext_glide_osc_in(osc),
        .rc_glide_osc_in(1'b0), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .note_select_n(note_select_n), .any_key_level(any_key_level),
        .priority_trigger_pulse(trig), .octave_code_bit0(ob0), .octave_code_bit1(ob1),
        .octave_code_bit2(ob2), .footage_square(footage_square), .footduty_out(footduty_out),
        .zero_pulse_out(zero_pulse_out));
    mkng_kbd_model mkng_kbd_model_i (.note_select_n(note_select_n), .pressed(pressed),
        .octave_return_n(ret_n), .priority_key_select(pks));
    initial begin
        forever #2.5 clock = ~clock;
    end
    // hang guard, width of each trigger pulse, and a 160 kHz glide oscillator
    always @(posedge clock) begin
        cyc++;
        if (cyc % 625 == 0) osc <= ~osc;
        if (trig === 1'b0) low_cnt++;
        if (cyc == 85000) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access: held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    // restart the scan, watch each line go low in turn, let the pick land
    task automatic settle();
        low_cnt = 0;
        sync_reset <= 1'b1;
        @(posedge clock);
        sync_reset <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            repeat (1000) @(posedge clock);
            chk({20'h0, note_select_n}, {20'h0, ~(12'h001 << k)});
            repeat (1000) @(posedge clock);
        end
        repeat (80) @(posedge clock); // pick plus the 50-cycle trigger must finish
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        chk({note_select_n, any_key_level, trig}, {12'hFFE, 2'h3});
        chk({ob2, ob1, ob0, footage_square, footduty_out, zero_pulse_out}, 32'h1C0);
        bus(1'b0, MKNG_CTRL_ADDR, 32'h0);
        chk(q & 32'h1, 32'h1);
        bus(1'b1, MKNG_CTRL_ADDR, 32'h0);
        bus(1'b0, MKNG_CTRL_ADDR, 32'h0);
        chk(q & 32'h1, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        $display("test registers done");
        pressed[39] <= 1'b1;
        pressed[40] <= 1'b1;
        settle();
        bus(1'b0, MKNG_STATUS_ADDR, 32'h0);
        chk(q & 32'hBF, 32'h80 | 32'd40);
        chk({ob2, ob1, ob0}, 32'h4);
        chk({any_key_level, trig, 8'(low_cnt)}, {2'h1, 8'd50});
        $display("test right priority done");
        bus(1'b1, MKNG_CTRL_ADDR, 32'h1);
        priority_right <= 1'b0;
        settle();
        bus(1'b0, MKNG_STATUS_ADDR, 32'h0);
        chk(q & 32'h3F, 32'd39);
        chk(q & 32'h3FF00, 32'h19800);
        chk({ob2, ob1, ob0, 8'(low_cnt)}, {3'h4, 8'd50});
        $display("test left priority done");
        pressed <= '0;
        settle();
        bus(1'b0, MKNG_STATUS_ADDR, 32'h0);
        chk(q & 32'hBF, 32'd39);
        chk({any_key_level, 8'(low_cnt)}, {1'b1, 8'd0});
        clamp <= 1'b1;
        repeat (2) @(posedge clock);
        chk({footage_square, footduty_out, zero_pulse_out}, 32'h0);
        clamp <= 1'b0;
        $display("test release done");
        stop_test();
    end
endmodule
